/* File: cbu_pkg.sv */
/*
  Constants, register map and types for the compare-and-branch unit.
  Assumes a 25 MHz system clock and Avalon-MM register access with byte addresses.
*/
package cbu_pkg;

  // word layout: bit 24 is the sign, bits 23:0 the magnitude
  localparam int WORD_W = 25;
  localparam int MAG_W = 24;
  localparam int SIGN_BIT = 24;
  localparam int ADDR_W = 15;
  localparam int AV_ADDR_W = 8;

  // instruction word fields
  localparam int INS_IA_BIT = 24;
  localparam int INS_X_LSB = 20;
  localparam int INS_OP_LSB = 14;
  localparam int INS_FLD_LSB = 10;
  localparam int INS_M_W = 10;

  // operation codes
  localparam logic [5:0] OPC_COMPARE = 6'h2C;
  localparam logic [5:0] OPC_MAGNITUDE = 6'h2D;
  localparam logic [5:0] OPC_ZEROS_COV = 6'h2E;
  localparam logic [5:0] OPC_ONES_COV = 6'h2F;
  localparam logic [5:0] OPC_BRANCH = 6'h30;
  localparam logic [5:0] OPC_JUMP = 6'h06;
  localparam logic [5:0] OPC_JUMP_RET = 6'h07;

  // indicator designations of the branch instruction
  localparam logic [3:0] IND_EQUAL = 4'h6;
  localparam logic [3:0] IND_HIGH = 4'h7;
  localparam logic [3:0] IND_LOW = 4'h5;
  localparam logic [3:0] IND_AR1 = 4'h1;
  localparam logic [3:0] IND_AR4 = 4'h4;

  // timing: one memory cycle is 4000 ns
  localparam int MEM_CYCLE_NS = 4000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLKS_PER_CYCLE = (MEM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] CYC_COMPARE = 2'd2;
  localparam logic [1:0] CYC_TAKEN = 2'd1;
  localparam logic [1:0] CYC_SEQUENTIAL = 2'd2;
  localparam logic [1:0] CYC_JUMP = 2'd1;
  localparam logic [1:0] CYC_JUMP_RET = 2'd3;
  localparam logic [1:0] CYC_OTHER = 2'd1;

  // register byte offsets
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_FIELD_MASK = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_CC = 8'h10;
  localparam logic [7:0] OFF_ARITH_RESULT = 8'h14;
  localparam logic [7:0] OFF_INDIRECT = 8'h18;
  localparam logic [7:0] OFF_STORE_ADDR = 8'h1C;
  localparam logic [7:0] OFF_STORE_DATA = 8'h20;
  localparam logic [7:0] OFF_MEM_HI = 8'h24;
  localparam logic [7:0] OFF_MEM_LO = 8'h28;
  localparam logic [7:0] OFF_AR_BASE = 8'h30;
  localparam logic [7:0] OFF_INDEX_BASE = 8'h40;

  // field positions
  localparam int CTRL_MULTIWORD = 0;
  localparam int CTRL_FIELD_SEL = 1;
  localparam int STAT_EQUAL = 0;
  localparam int STAT_HIGH = 1;
  localparam int STAT_LOW = 2;
  localparam int STAT_BUSY = 3;
  localparam int STAT_UNSUPPORTED = 4;

  // reset values
  localparam logic [WORD_W-1:0] RST_WORD = 25'h000_0000;
  localparam logic [ADDR_W-1:0] RST_ADDR = 15'h0000;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [MAG_W-1:0] RST_FIELD_MASK = 24'hFF_FFFF;
  localparam logic [31:0] RST_READ = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN = 3'b100
  } exec_state_e;

endpackage

/* File: compare_and_branch_unit.sv */
/*
  Compare-and-branch unit: four comparisons that drive the high, low and equal
  flags, indicator and sign-test branches, jump and jump-with-return, all timed in
  memory cycles. Assumes software loads operands, index registers and the
  instruction over Avalon-MM, and that memory storage takes the return word from
  the store outputs.
*/
// Implementation choices: the Avalon-MM slave port and the register addresses.
// Summary of operation
// - each compare sets exactly one of high, low, equal and clears the others
// - algebraic compare takes two cycles: high if greater, low if smaller, else equal
// - compares order magnitudes by raw unsigned binary value of the bits
// - multiword algebraic compare uses only the least significant word's sign
// - field selection compares chosen bits only; memory sign counts as positive
// - positive zero ranks above negative zero in the algebraic compare
// - magnitude compare takes two cycles and ignores all signs
// - ones coverage: equal if memory has a one wherever register has one, else high
// - zeros coverage: equal if memory has a zero wherever register has one, else high
// - coverage compares include signs unless field selection, which drops them
// - all-zero register operand in a coverage compare always gives equal
// - compares never change the operands, only the flags
// - branch loads target if tested flag set, else counter plus one; flag kept
// - flag branch takes one cycle when taken, two when not
// - branch op shares one code; field 0110 equal, 0111 high, 0101 low
// - add and subtract results set equal when zero, clear it otherwise
// - sign test branches in one cycle if positive, else two cycles in sequence
// - sign test field 0001 to 0100 selects arithmetic register one to four
// - jump loads the counter with the indexed address
// - jump with return stores next address, continues after the stored location
// - compares take indirect, multiword, field select; branches take indirect target
`timescale 1ns/1ns
module compare_and_branch_unit (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // avalon-mm register slave
  input wire logic [cbu_pkg::AV_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // indicators and sequencing
  output logic equal_flag,
  output logic high_flag,
  output logic low_flag,
  output logic [cbu_pkg::ADDR_W-1:0] control_counter,
  output logic busy,
  // return word towards memory storage
  output logic store_valid,
  output logic [cbu_pkg::ADDR_W-1:0] store_address,
  output logic [cbu_pkg::WORD_W-1:0] store_data
);
  import cbu_pkg::*;

  function automatic logic at(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // eq, high, low from a strict-order outcome
  function automatic logic [2:0] flags3(input logic hi, input logic lo);
    return {~hi & ~lo, hi, lo};
  endfunction

  // registers
  logic wait_ff;
  logic [31:0] rdata_ff;
  exec_state_e state_ff;
  logic busy_ff;
  logic [8:0] cnt_ff;
  logic [WORD_W-1:0] instr_ff;
  logic [1:0] ctrl_ff;
  logic [MAG_W-1:0] mask_ff;
  logic [ADDR_W-1:0] cc_ff;
  logic [ADDR_W-1:0] indirect_ff;
  logic [WORD_W-1:0] mem_hi_ff;
  logic [WORD_W-1:0] mem_lo_ff;
  logic [WORD_W-1:0] ar_ff [0:3];
  logic [ADDR_W-1:0] idx_ff [0:15];
  logic eq_ff;
  logic hi_ff;
  logic lo_ff;
  logic unsup_ff;
  logic store_valid_ff;
  logic [ADDR_W-1:0] store_addr_ff;
  logic [WORD_W-1:0] store_data_ff;

  // bus decode
  wire req = read | write;
  wire stall = write & busy_ff;
  wire nxt_wait = ~(req & wait_ff & ~stall);
  wire wr_en = write & ~wait_ff;
  wire [31:0] wr_word_ctrl = be_merge(32'(ctrl_ff), writedata, byteenable);
  wire [31:0] wr_word_mask = be_merge(32'(mask_ff), writedata, byteenable);
  wire [31:0] wr_word_cc = be_merge(32'(cc_ff), writedata, byteenable);
  wire [31:0] wr_word_ind = be_merge(32'(indirect_ff), writedata, byteenable);
  wire [31:0] wr_word_mhi = be_merge(32'(mem_hi_ff), writedata, byteenable);
  wire [31:0] wr_word_mlo = be_merge(32'(mem_lo_ff), writedata, byteenable);
  wire [31:0] wr_word_ins = be_merge(32'(instr_ff), writedata, byteenable);
  wire [31:0] wr_word_arith = be_merge(32'h0000_0000, writedata, byteenable);
  wire wr_instr = wr_en & at(address, OFF_INSTR);
  wire wr_ctrl = wr_en & at(address, OFF_CTRL);
  wire wr_mask = wr_en & at(address, OFF_FIELD_MASK);
  wire wr_cc = wr_en & at(address, OFF_CC);
  wire wr_arith = wr_en & at(address, OFF_ARITH_RESULT);
  wire wr_ind = wr_en & at(address, OFF_INDIRECT);
  wire wr_mhi = wr_en & at(address, OFF_MEM_HI);
  wire wr_mlo = wr_en & at(address, OFF_MEM_LO);
  wire in_ar = address[7:4] == OFF_AR_BASE[7:4];
  wire in_idx = address[7:6] == OFF_INDEX_BASE[7:6];

  // instruction fields
  wire ins_ia = instr_ff[INS_IA_BIT];
  wire [3:0] ins_x = instr_ff[INS_X_LSB +: 4];
  wire [5:0] ins_op = instr_ff[INS_OP_LSB +: 6];
  wire [3:0] ins_fld = instr_ff[INS_FLD_LSB +: 4];
  wire [ADDR_W-1:0] ins_m = ADDR_W'(instr_ff[INS_M_W-1:0]);
  wire [ADDR_W-1:0] eff_addr = ins_m + idx_ff[ins_x];
  wire [ADDR_W-1:0] target = ins_ia ? indirect_ff : eff_addr;

  // operand assembly; register and memory contents are only read here
  wire mw = ctrl_ff[CTRL_MULTIWORD];
  wire fsel = ins_ia & ctrl_ff[CTRL_FIELD_SEL];
  wire [1:0] ar_idx = 2'(ins_fld - IND_AR1);
  wire [WORD_W-1:0] ar_sel = ar_ff[ar_idx];
  wire [47:0] r_mag = mw ? {ar_ff[0][MAG_W-1:0], ar_ff[1][MAG_W-1:0]}
                         : {24'h00_0000, ar_sel[MAG_W-1:0]};
  wire [47:0] m_mag = mw ? {mem_hi_ff[MAG_W-1:0], mem_lo_ff[MAG_W-1:0]}
                         : {24'h00_0000, mem_lo_ff[MAG_W-1:0]};
  wire r_sign = mw ? ar_ff[1][SIGN_BIT] : ar_sel[SIGN_BIT];
  wire m_sign_raw = mem_lo_ff[SIGN_BIT];
  wire m_sign = fsel ? 1'b0 : m_sign_raw;
  wire [47:0] msk = fsel ? {mw ? mask_ff : 24'h00_0000, mask_ff}
                         : 48'hFFFF_FFFF_FFFF;
  wire [47:0] ra = r_mag & msk;
  wire [47:0] ma = m_mag & msk;
  wire mag_gt = ra > ma;
  wire mag_lt = ra < ma;

  // algebraic: signs differ means the positive side wins, zeros included
  wire alg_hi = (r_sign != m_sign) ? ~r_sign : (r_sign ? mag_lt : mag_gt);
  wire alg_lo = (r_sign != m_sign) ? r_sign : (r_sign ? mag_gt : mag_lt);
  wire [2:0] alg_flags = flags3(alg_hi, alg_lo);
  wire [2:0] abs_flags = flags3(mag_gt, mag_lt);

  // coverage vectors carry both signs unless field selection drops them
  wire [49:0] r_bits = fsel ? {2'b00, ra} : {mw & ar_ff[0][SIGN_BIT], r_sign, r_mag};
  wire [49:0] m_bits = fsel ? {2'b00, ma}
                            : {mw & mem_hi_ff[SIGN_BIT], m_sign_raw, m_mag};
  wire ones_ok = ~|(r_bits & ~m_bits);
  wire zeros_ok = ~|(r_bits & m_bits);
  wire r_zero = ~|r_bits;
  wire cov_eq = r_zero | ((ins_op == OPC_ONES_COV) ? ones_ok : zeros_ok);
  wire [2:0] cov_flags = flags3(~cov_eq, 1'b0);

  // branch condition
  wire is_sign_test = (ins_fld >= IND_AR1) && (ins_fld <= IND_AR4);
  wire test_val = (ins_fld == IND_EQUAL) ? eq_ff :
                  (ins_fld == IND_HIGH) ? hi_ff :
                  (ins_fld == IND_LOW) ? lo_ff :
                  is_sign_test ? ~ar_sel[SIGN_BIT] : 1'b0;

  // per-operation outcome
  wire is_cmp = (ins_op == OPC_COMPARE) || (ins_op == OPC_MAGNITUDE);
  wire is_cov = (ins_op == OPC_ONES_COV) || (ins_op == OPC_ZEROS_COV);
  wire is_branch = ins_op == OPC_BRANCH;
  wire is_jump = ins_op == OPC_JUMP;
  wire is_ret = ins_op == OPC_JUMP_RET;
  wire known = is_cmp | is_cov | is_branch | is_jump | is_ret;
  wire [2:0] cmp_flags = (ins_op == OPC_COMPARE) ? alg_flags :
                         (ins_op == OPC_MAGNITUDE) ? abs_flags : cov_flags;
  wire [ADDR_W-1:0] cc_next_seq = cc_ff + 15'h0001;
  wire [ADDR_W-1:0] exec_cc = is_jump ? target :
                              is_ret ? target + 15'h0001 :
                              (is_branch & test_val) ? target :
                              known ? cc_next_seq : cc_ff;
  wire [1:0] exec_cyc = (is_cmp | is_cov) ? CYC_COMPARE :
                        is_branch ? (test_val ? CYC_TAKEN : CYC_SEQUENTIAL) :
                        is_jump ? CYC_JUMP :
                        is_ret ? CYC_JUMP_RET : CYC_OTHER;
  wire [8:0] exec_clks = 9'(int'(exec_cyc) * CLKS_PER_CYCLE);
  wire done = (state_ff == ST_RUN) && (cnt_ff == 9'h000);

  // sequencer: load cycle plus run cycles give exactly exec_clks busy clocks
  exec_state_e nxt_state;
  logic [8:0] nxt_cnt;
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        if (wr_instr) begin
          nxt_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        nxt_state = ST_RUN;
        nxt_cnt = exec_clks - 9'h002;
      end
      ST_RUN: begin
        if (cnt_ff == 9'h000) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 9'h001;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  wire nxt_busy = nxt_state != ST_IDLE;

  // read mux
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = RST_READ;
    if (at(address, OFF_INSTR)) begin
      nxt_rdata = 32'(instr_ff);
    end else if (at(address, OFF_CTRL)) begin
      nxt_rdata = 32'(ctrl_ff);
    end else if (at(address, OFF_FIELD_MASK)) begin
      nxt_rdata = 32'(mask_ff);
    end else if (at(address, OFF_STATUS)) begin
      nxt_rdata = 32'({unsup_ff, busy_ff, lo_ff, hi_ff, eq_ff});
    end else if (at(address, OFF_CC)) begin
      nxt_rdata = 32'(cc_ff);
    end else if (at(address, OFF_INDIRECT)) begin
      nxt_rdata = 32'(indirect_ff);
    end else if (at(address, OFF_STORE_ADDR)) begin
      nxt_rdata = 32'(store_addr_ff);
    end else if (at(address, OFF_STORE_DATA)) begin
      nxt_rdata = 32'(store_data_ff);
    end else if (at(address, OFF_MEM_HI)) begin
      nxt_rdata = 32'(mem_hi_ff);
    end else if (at(address, OFF_MEM_LO)) begin
      nxt_rdata = 32'(mem_lo_ff);
    end else if (in_ar) begin
      nxt_rdata = 32'(ar_ff[address[3:2]]);
    end else if (in_idx) begin
      nxt_rdata = 32'(idx_ff[address[5:2]]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff <= 1'b1;
      rdata_ff <= RST_READ;
      state_ff <= ST_IDLE;
      busy_ff <= 1'b0;
      cnt_ff <= 9'h000;
    end else begin
      wait_ff <= nxt_wait;
      rdata_ff <= (~nxt_wait & read) ? nxt_rdata : rdata_ff;
      state_ff <= nxt_state;
      busy_ff <= nxt_busy;
      cnt_ff <= nxt_cnt;
    end
  end

  // software-held configuration; all writes are stalled while busy
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      instr_ff <= RST_WORD;
      ctrl_ff <= RST_CTRL;
      mask_ff <= RST_FIELD_MASK;
      indirect_ff <= RST_ADDR;
      mem_hi_ff <= RST_WORD;
      mem_lo_ff <= RST_WORD;
    end else begin
      if (wr_instr) instr_ff <= wr_word_ins[WORD_W-1:0];
      if (wr_ctrl) ctrl_ff <= wr_word_ctrl[1:0];
      if (wr_mask) mask_ff <= wr_word_mask[MAG_W-1:0];
      if (wr_ind) indirect_ff <= wr_word_ind[ADDR_W-1:0];
      if (wr_mhi) mem_hi_ff <= wr_word_mhi[WORD_W-1:0];
      if (wr_mlo) mem_lo_ff <= wr_word_mlo[WORD_W-1:0];
    end
  end

  // arithmetic registers: written by software only, never by execution
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_ar
      wire wr_this = wr_en & in_ar & (address[3:2] == 2'(g));
      wire [31:0] wr_word = be_merge(32'(ar_ff[g]), writedata, byteenable);
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          ar_ff[g] <= RST_WORD;
        end else if (wr_this) begin
          ar_ff[g] <= wr_word[WORD_W-1:0];
        end
      end
    end
    // index zero stays zero so designation zero means no indexing
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        idx_ff[0] <= RST_ADDR;
      end else begin
        idx_ff[0] <= RST_ADDR;
      end
    end
    for (g = 1; g < 16; g++) begin : gen_idx
      wire wr_this = wr_en & in_idx & (address[5:2] == 4'(g));
      wire [31:0] wr_word = be_merge(32'(idx_ff[g]), writedata, byteenable);
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          idx_ff[g] <= RST_ADDR;
        end else if (wr_this) begin
          idx_ff[g] <= wr_word[ADDR_W-1:0];
        end
      end
    end
  endgenerate

  // indicators and counter update at the end of the instruction, or when software writes the arithmetic result or counter
  wire arith_zero = ~|wr_word_arith[MAG_W-1:0];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      eq_ff <= 1'b0;
      hi_ff <= 1'b0;
      lo_ff <= 1'b0;
      cc_ff <= RST_ADDR;
      unsup_ff <= 1'b0;
    end else begin
      if (done & (is_cmp | is_cov)) begin
        {eq_ff, hi_ff, lo_ff} <= cmp_flags;
      end else if (wr_arith) begin
        eq_ff <= arith_zero;
      end
      if (done) begin
        cc_ff <= exec_cc;
        unsup_ff <= ~known;
      end else if (wr_cc) begin
        cc_ff <= wr_word_cc[ADDR_W-1:0];
      end
    end
  end

  // return word: next sequential address in bits 14:0, upper bits cleared
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      store_valid_ff <= 1'b0;
      store_addr_ff <= RST_ADDR;
      store_data_ff <= RST_WORD;
    end else begin
      store_valid_ff <= done & is_ret;
      if (done & is_ret) begin
        store_addr_ff <= target;
        store_data_ff <= WORD_W'(cc_next_seq);
      end
    end
  end

  assign readdata = rdata_ff;
  assign waitrequest = wait_ff;
  assign equal_flag = eq_ff;
  assign high_flag = hi_ff;
  assign low_flag = lo_ff;
  assign control_counter = cc_ff;
  assign busy = busy_ff;
  assign store_valid = store_valid_ff;
  assign store_address = store_addr_ff;
  assign store_data = store_data_ff;

endmodule

/* File: cbu_assertions.sv */
/*
  Port checker for the unit.
  Assumes a bind onto the top module.
*/
`timescale 1ns/1ns
module cbu_assertions (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register bus
  input wire logic [cbu_pkg::AV_ADDR_W-1:0] address,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic waitrequest,
  // indicators and sequencing
  input wire logic equal_flag,
  input wire logic high_flag,
  input wire logic low_flag,
  input wire logic [cbu_pkg::ADDR_W-1:0] control_counter,
  input wire logic busy,
  // return word
  input wire logic store_valid,
  input wire logic [cbu_pkg::ADDR_W-1:0] store_address,
  input wire logic [cbu_pkg::WORD_W-1:0] store_data
);
  import cbu_pkg::*;
  localparam int ONE_CLKS = CLKS_PER_CYCLE;
  logic [5:0] op_ff;
  // ia, index and address field
  logic [14:0] mx_ff;
  int busy_cnt_ff;
  wire instr_commit = write && !waitrequest && address[7:2] == 6'h00;
  wire is_cmp = op_ff[5:2] == 4'hB;
  wire [2:0] flags = {low_flag, high_flag, equal_flag};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      op_ff <= 6'h00;
      mx_ff <= 15'h0000;
      busy_cnt_ff <= 0;
    end else begin
      busy_cnt_ff <= busy ? busy_cnt_ff + 1 : 0;
      if (instr_commit) begin
        op_ff <= writedata[19:14];
        mx_ff <= {writedata[24:20], writedata[9:0]};
      end
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence ret_done_s;
    $fell(busy) && op_ff == OPC_JUMP_RET;
  endsequence
  sequence ret_word_s;
    ##[0:1] store_valid && store_data[24:15] == 10'h000 &&
      store_address + 15'h0001 == control_counter;
  endsequence
  wait_one_cycle_a: assert property (!waitrequest |=> waitrequest)
    else $error("long wait");
  commit_starts_a: assert property (instr_commit |=> busy)
    else $error("no start");
  held_write_a: assert property (busy && write |-> waitrequest)
    else $error("busy write");
  cmp_onehot_a: assert property ($fell(busy) && is_cmp |-> $onehot(flags))
    else $error("flags not one-hot");
  cmp_length_a: assert property ($fell(busy) && is_cmp |-> busy_cnt_ff == 2 * ONE_CLKS)
    else $error("compare length");
  branch_keeps_a: assert property ($fell(busy) && op_ff == OPC_BRANCH |-> flags == $past(flags))
    else $error("flags changed");
  branch_time_a: assert property ($fell(busy) && op_ff == OPC_BRANCH |->
    busy_cnt_ff == ONE_CLKS ||
    (busy_cnt_ff == 2 * ONE_CLKS && control_counter == $past(control_counter) + 15'h0001))
    else $error("branch timing");
  jump_target_a: assert property ($fell(busy) && op_ff == OPC_JUMP && mx_ff[14:10] == 5'h00
    |-> control_counter == {5'h00, mx_ff[9:0]})
    else $error("jump target");
  ret_word_a: assert property (ret_done_s |-> ret_word_s)
    else $error("no return word");
endmodule

/* File: ret_store_model.sv */
/*
  Return-word store model.
  Assumes one-cycle store pulses on clk_sys.
*/
`timescale 1ns/1ns
module ret_store_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // store port of the unit
  input wire logic store_valid,
  input wire logic [cbu_pkg::ADDR_W-1:0] store_address,
  input wire logic [cbu_pkg::WORD_W-1:0] store_data,
  // last word kept
  output logic [cbu_pkg::ADDR_W-1:0] kept_address,
  output logic [cbu_pkg::WORD_W-1:0] kept_data
);
  import cbu_pkg::*;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      kept_address <= RST_ADDR;
      kept_data <= RST_WORD;
    end else if (store_valid) begin
      kept_address <= store_address;
      kept_data <= store_data;
    end
  end
endmodule

/* File: compare_and_branch_unit_tb_top.sv */
/*
  Bench for the compare-and-branch unit.
  Assumes cbu_pkg timing; checker bound below.
*/
`timescale 1ns/1ns
module compare_and_branch_unit_tb_top;
  import cbu_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata, rd, r;
  logic waitrequest, equal_flag, high_flag, low_flag, busy, store_valid, tk;
  logic [14:0] control_counter, store_address, kept_address;
  logic [24:0] store_data, kept_data, a, b;
  logic [2:0] fl;
  int bad_count = 0;
  int comparisons = 0;
  int cc_m = 0;
  logic [31:0] seed = 32'h0000_2D52;
  logic [5:0] ops [4] = '{OPC_COMPARE, OPC_MAGNITUDE, OPC_ZEROS_COV, OPC_ONES_COV};
  logic [3:0] inds [3] = '{IND_EQUAL, IND_HIGH, IND_LOW};
  logic [7:0] ra [5] = '{OFF_STATUS, OFF_CC, OFF_FIELD_MASK, 8'h84, OFF_INDEX_BASE};
  logic [31:0] re [5] = '{32'h0000_0000, 32'h0000_0000, 32'h00FF_FFFF, 32'h0000_0000,
    32'h0000_0000};
  // corner cases: signed zeros, raw order, signs ignored, coverage, field select
  logic [5:0] d_op [7] = '{OPC_COMPARE, OPC_COMPARE, OPC_MAGNITUDE, OPC_MAGNITUDE,
    OPC_ZEROS_COV, OPC_ONES_COV, OPC_ONES_COV};
  logic [24:0] d_a [7] = '{25'h000_0000, 25'h100_0000, 25'h000_003F, 25'h100_0005,
    25'h000_0000, 25'h100_0000, 25'h1AB_CD0F};
  logic [24:0] d_b [7] = '{25'h100_0000, 25'h000_0000, 25'h000_0000, 25'h000_0005,
    25'h1FF_FFFF, 25'h000_0000, 25'h000_000F};

  compare_and_branch_unit dut_u (.clk_sys, .rst_n, .address, .read, .write, .writedata,
    .byteenable(4'hF), .readdata, .waitrequest, .equal_flag, .high_flag, .low_flag,
    .control_counter, .busy, .store_valid, .store_address, .store_data);
  ret_store_model mem_u (.clk_sys, .rst_n, .store_valid, .store_address, .store_data,
    .kept_address, .kept_data);

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [24:0] ins(input logic ia, input logic [3:0] x,
      input logic [5:0] op, input logic [3:0] f, input logic [9:0] m);
    return {ia, x, op, f, m};
  endfunction

  // expected {low, high, equal}; minus zero maps below plus zero
  function automatic logic [2:0] model(input logic [5:0] op, input logic [24:0] p,
      input logic [24:0] q, input logic [23:0] mk, input logic fs);
    int x, y;
    logic [24:0] pm, qm;
    pm = fs ? {1'b0, p[23:0] & mk} : p;
    qm = fs ? {1'b0, q[23:0] & mk} : q;
    x = pm[23:0];
    y = qm[23:0];
    if (op == OPC_ZEROS_COV) return ((pm & qm) == 25'h000_0000) ? 3'b001 : 3'b010;
    if (op == OPC_ONES_COV) return ((pm & ~qm) == 25'h000_0000) ? 3'b001 : 3'b010;
    if (op == OPC_COMPARE) begin
      x = p[24] ? -x - 1 : x;
      y = qm[24] ? -y - 1 : y;
    end
    return (x > y) ? 3'b010 : (x < y) ? 3'b100 : 3'b001;
  endfunction

  task automatic fail_msg(input string msg);
    bad_count++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) fail_msg($sformatf("got %h exp %h", got, exp));
  endtask

  task automatic check_state(input logic [2:0] f);
    comparisons++;
    if ({low_flag, high_flag, equal_flag, control_counter} !== {f, cc_m[14:0]})
      fail_msg($sformatf("state %b %h", {low_flag, high_flag, equal_flag}, control_counter));
  endtask

  // request stands until waitrequest is sampled low; data taken at that edge
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    address <= ad;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic exec(input logic [24:0] w);
    bus(1'b1, OFF_INSTR, {7'h00, w});
    do @(negedge clk_sys); while (busy !== 1'b0);
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic do_cmp(input logic [5:0] op, input logic [24:0] x, input logic [24:0] y,
      input logic fs);
    logic [23:0] mk;
    mk = fs ? 24'h00_00FF : 24'hFF_FFFF;
    bus(1'b1, OFF_AR_BASE, {7'h00, x});
    bus(1'b1, OFF_MEM_LO, {7'h00, y});
    bus(1'b1, OFF_CTRL, fs ? 32'h0000_0002 : 32'h0000_0000);
    bus(1'b1, OFF_FIELD_MASK, {8'h00, mk});
    exec(ins(fs, 4'h0, op, 4'h1, 10'h000));
    cc_m = cc_m + 1;
    fl = model(op, x, y, mk, fs);
    check_state(fl);
    bus(1'b0, OFF_AR_BASE, 32'h0000_0000);
    cmp_reg(rd, {7'h00, x});
    bus(1'b0, OFF_MEM_LO, 32'h0000_0000);
    cmp_reg(rd, {7'h00, y});
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk_sys);
    fail_msg("watchdog expired");
    conclude();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus(1'b1, OFF_INDEX_BASE, 32'h0000_0055);
    bus(1'b1, 8'h84, 32'h0000_1234);
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0000_0000);
      cmp_reg(rd, re[i]);
    end
    $display("test reset done");
    bus(1'b1, OFF_INDEX_BASE + 8'h0C, 32'h0000_0010);
    bus(1'b1, OFF_INDIRECT, 32'h0000_0155);
    foreach (d_op[i]) do_cmp(d_op[i], d_a[i], d_b[i], i == 6);
    foreach (ops[j]) begin
      for (int k = 0; k < 4; k++) begin
        r = rnd();
        a = (k == 0) ? 25'h000_0000 : r[24:0];
        r = rnd();
        b = (ops[j] == OPC_ZEROS_COV) ? ~a & r[24:0] : a | r[24:0];
        b = (k == 2) ? a : (k == 1) ? b : r[24:0];
        do_cmp(ops[j], a, b, 1'b0);
      end
    end
    $display("test compares done");
    bus(1'b1, OFF_ARITH_RESULT, 32'h0100_0000);
    repeat (2) @(negedge clk_sys);
    cmp_reg({31'h0, equal_flag}, 32'h0000_0001);
    bus(1'b1, OFF_ARITH_RESULT, 32'h0000_0010);
    repeat (2) @(negedge clk_sys);
    cmp_reg({31'h0, equal_flag}, 32'h0000_0000);
    $display("test arithmetic result done");
    for (int s = 0; s < 3; s++) begin
      b = (s == 0) ? 25'h000_0003 : (s == 1) ? 25'h000_0005 : 25'h000_0004;
      do_cmp(OPC_MAGNITUDE, 25'h000_0004, b, 1'b0);
      foreach (inds[i]) begin
        exec(ins(i[0], 4'h3, OPC_BRANCH, inds[i], 10'h020));
        tk = (inds[i] == IND_EQUAL) ? fl[0] : (inds[i] == IND_HIGH) ? fl[1] : fl[2];
        cc_m = !tk ? cc_m + 1 : i[0] ? 32'h0000_0155 : 32'h0000_0030;
        check_state(fl);
      end
    end
    for (int k = 1; k < 5; k++) begin
      r = rnd();
      bus(1'b1, OFF_AR_BASE + 8'(4 * (k - 1)), {7'h00, k[0], r[23:0]});
      exec(ins(1'b0, 4'h0, OPC_BRANCH, 4'(k), 10'h040));
      cc_m = k[0] ? cc_m + 1 : 32'h0000_0040;
      check_state(fl);
    end
    $display("test branches done");
    exec(ins(1'b0, 4'h3, OPC_JUMP, 4'h0, 10'h100));
    cc_m = 32'h0000_0110;
    check_state(fl);
    exec(ins(1'b0, 4'h0, OPC_JUMP_RET, 4'h1, 10'h200));
    cmp_reg({17'h0_0000, kept_address}, 32'h0000_0200);
    cmp_reg({7'h00, kept_data}, 32'(cc_m + 1));
    cc_m = 32'h0000_0201;
    check_state(fl);
    $display("test jumps done");
    exec(ins(1'b0, 4'h0, 6'h3F, 4'h0, 10'h000));
    bus(1'b0, OFF_STATUS, 32'h0000_0000);
    cmp_reg({27'h000_0000, rd[4:0]}, {27'h000_0000, 2'b10, fl});
    check_state(fl);
    bus(1'b1, OFF_INSTR, {7'h00, ins(1'b0, 4'h0, OPC_JUMP, 4'h0, 10'h0AB)});
    // held off until the jump ends
    bus(1'b1, OFF_CC, 32'h0000_0077);
    repeat (2) @(negedge clk_sys);
    cc_m = 32'h0000_0077;
    check_state(fl);
    $display("test unknown op and stall done");
    conclude();
  end
endmodule

bind compare_and_branch_unit cbu_assertions chk_u (.clk_sys, .rst_n, .address, .write,
  .writedata, .waitrequest, .equal_flag, .high_flag, .low_flag, .control_counter, .busy,
  .store_valid, .store_address, .store_data);
